// ---- rtl/modbus_writer_pkg.sv ----
package modbus_writer_pkg;

    // Function codes and exception answers
    localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
    localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
    localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
    localparam logic [7:0] EXC_BAD_VALUE = 8'h03;
    localparam logic [7:0] BROADCAST_ADDR = 8'h00;

    // Frame check sequence
    localparam logic [15:0] CRC_SEED = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] CRC_GOOD = 16'h0000;

    // Frame layout, in byte positions
    localparam int HDR_BYTES = 7;
    localparam logic [8:0] DATA_START = 9'h007;
    localparam logic [8:0] MIN_FRAME = 9'h004;
    localparam logic [8:0] SINGLE_LEN = 9'h008;
    localparam logic [8:0] MULTI_OVERHEAD = 9'h009;
    localparam logic [8:0] RX_CNT_MAX = 9'h1FF;
    localparam logic [2:0] RESP_LEN_OK = 3'h6;
    localparam logic [2:0] RESP_LEN_EXC = 3'h3;

    // Block write limits
    localparam int MIN_WRITE = 1;
    localparam int MAX_WRITE = 123;

    // Register map: link address of the first map word (register number minus one)
    localparam logic [15:0] MAP_BASE = 16'h9C40;
    localparam int NUM_MODELS = 29;
    localparam int MODEL_LEN = 4;
    localparam int MODEL_SPAN = MODEL_LEN + 2;
    localparam int MAP_DEPTH = NUM_MODELS * MODEL_SPAN + 2;
    localparam int MAP_AW = $clog2(MAP_DEPTH);
    localparam logic [15:0] END_MODEL_ID = 16'hFFFF;
    localparam logic [15:0] MODEL_IDS [NUM_MODELS] = '{
        16'h0001, 16'h0011, 16'h0067, 16'h0078, 16'h0079, 16'h007A, 16'h007B, 16'h007E,
        16'h0081, 16'h0082, 16'h0084, 16'h0086, 16'h0087, 16'h0088, 16'h008B, 16'h008C,
        16'h008F, 16'h0090, 16'h0091, 16'hFD20, 16'hFB2C, 16'hFB2D, 16'hFB2E, 16'hFB2F,
        16'hFB30, 16'hFB31, 16'hFB32, 16'hFB33, 16'hFB34};

    // Reset content of one map word: model id, model length, then body
    function automatic logic [15:0] map_init(input int idx);
        int m;
        int k;
        m = idx / MODEL_SPAN;
        k = idx % MODEL_SPAN;
        if (m >= NUM_MODELS) begin
            map_init = (k == 0) ? END_MODEL_ID : 16'h0000;
        end else if (k == 0) begin
            map_init = MODEL_IDS[m];
        end else if (k == 1) begin
            map_init = 16'(MODEL_LEN);
        end else begin
            map_init = 16'h0000;
        end
    endfunction

    // Only model bodies take writes; id and length words are fixed
    function automatic logic map_writable(input int idx);
        map_writable = (idx / MODEL_SPAN < NUM_MODELS) && (idx % MODEL_SPAN >= 2);
    endfunction

endpackage

// ---- rtl/modbus_crc16.sv ----
`timescale 1ns/10ps
module modbus_crc16 (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Byte stream
    input wire logic clear,
    input wire logic en,
    input wire logic [7:0] data,
    // Check value
    output logic [15:0] crc,
    output logic [15:0] crc_next
);

    // Byte-wide step of the reflected polynomial
    always_comb begin
        crc_next = crc ^ {8'h00, data};
        for (int b = 0; b < 8; b++) begin
            crc_next = crc_next[0] ? ((crc_next >> 1) ^ modbus_writer_pkg::CRC_POLY)
                                   : (crc_next >> 1);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            crc <= modbus_writer_pkg::CRC_SEED;
        end else if (clear) begin
            crc <= modbus_writer_pkg::CRC_SEED;
        end else if (en) begin
            crc <= crc_next;
        end
    end

endmodule

// ---- rtl/modbus_rtu_register_writer.sv ----
// Function
// R1 - Function 06 writes one holding register at the given address with the value
// R2 - Link addresses are zero-based: register number minus one
// R3 - Function 06 success echoes the request, sent after the register is written
// R4 - Master sends 06 as address, function, register address, value, CRC
// R5 - Function 06 failure replies address, 0x86, exception code, CRC
// R6 - Function 16 writes 1 to 123 contiguous registers from the start address
// R7 - Master sends 16 as start, count, byte count, data words, CRC
// R8 - Function 16 success replies address, function, start, count, CRC only
// R9 - Function 16 failure replies address, 0x90, exception code, CRC
// R10 - Map begins with the common model, identifier 1
// R11 - Map ends with the end model, identifier all ones
// R12 - Map holds the fixed set of numbered models, each by its id
// R13 - Sixteen-bit fields travel most significant byte first
// R14 - CRC travels low byte first, then high byte
// R15 - Frames with CRC or parity errors are dropped without reply
// R16 - Exception codes: 01 bad function, 02 bad address, 03 bad value
// R17 - Bad count or byte count gives exception 03 and writes nothing
// R18 - Block writes go in ascending order, none if any address invalid
`timescale 1ns/10ps
module modbus_rtu_register_writer #(
    parameter int MAX_WRITE = modbus_writer_pkg::MAX_WRITE
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Station identity
    input wire logic [7:0] slave_addr,
    // Received characters
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    input wire logic rx_error,
    input wire logic rx_frame_end,
    // Reply characters
    output logic [7:0] tx_byte,
    output logic tx_valid,
    input wire logic tx_ready,
    // Register update notice
    output logic wr_strobe,
    output logic [15:0] wr_addr,
    output logic [15:0] wr_data,
    // Map read port
    input wire logic [modbus_writer_pkg::MAP_AW-1:0] map_rd_index,
    output logic [15:0] map_rd_data,
    // Status
    output logic busy
);

    localparam int DEPTH = modbus_writer_pkg::MAP_DEPTH;
    localparam int AW = modbus_writer_pkg::MAP_AW;

    typedef enum logic [1:0] {
        ST_RX = 2'b00,
        ST_CHECK = 2'b01,
        ST_WRITE = 2'b11,
        ST_SEND = 2'b10
    } state_t;

    state_t state, next_state;
    logic [7:0] hdr [modbus_writer_pkg::HDR_BYTES];
    logic [8:0] rx_cnt;
    logic rx_bad;
    logic [7:0] stage_hi;
    logic [15:0] stage [MAX_WRITE];
    logic [15:0] map [DEPTH];
    logic [6:0] wr_i;
    logic exc;
    logic [7:0] exc_code;
    logic [2:0] resp_len;
    logic [2:0] tx_idx;
    logic [15:0] rx_crc, tx_crc, tx_crc_next;

    // Decoded request fields
    wire logic rx_take = (state == ST_RX) && rx_valid;
    wire logic frame_done = (state == ST_RX) && rx_frame_end;
    wire logic [7:0] func = hdr[1];
    // R13 high byte first
    wire logic [15:0] reg_addr = {hdr[2], hdr[3]};
    wire logic [15:0] reg_val = {hdr[4], hdr[5]};
    wire logic [7:0] byte_count = hdr[6];
    wire logic is_single = func == modbus_writer_pkg::FC_WRITE_SINGLE;
    wire logic is_multi = func == modbus_writer_pkg::FC_WRITE_MULTI;
    wire logic [8:0] data_idx = rx_cnt - modbus_writer_pkg::DATA_START;

    // R2 zero-based offset
    wire logic [15:0] off = reg_addr - modbus_writer_pkg::MAP_BASE;
    wire logic in_map = (reg_addr >= modbus_writer_pkg::MAP_BASE) && (off < 16'(DEPTH));
    wire logic [16:0] span_end = {1'b0, off} + {1'b0, reg_val};
    wire logic multi_fits = in_map && (span_end <= 17'(DEPTH));
    logic [DEPTH-1:0] writable;
    logic [DEPTH-1:0] header_hit;

    // R17 count and byte count check
    wire logic count_ok = (reg_val >= 16'(modbus_writer_pkg::MIN_WRITE))
        && (reg_val <= 16'(MAX_WRITE)) && ({8'h00, byte_count} == {reg_val[14:0], 1'b0});
    wire logic single_ok = in_map && writable[off[AW-1:0]];
    // R18 reject whole block on any bad address
    wire logic multi_ok = multi_fits && !(|header_hit);

    // R15 drop damaged frames
    wire logic frame_ok = (rx_crc == modbus_writer_pkg::CRC_GOOD) && !rx_bad
        && (rx_cnt >= modbus_writer_pkg::MIN_FRAME);
    wire logic addressed = (hdr[0] == slave_addr) || (hdr[0] == modbus_writer_pkg::BROADCAST_ADDR);
    // R4 fixed single-write length
    wire logic len_ok = is_single ? (rx_cnt == modbus_writer_pkg::SINGLE_LEN)
        // R7 length follows byte count
        : is_multi ? (rx_cnt == modbus_writer_pkg::MULTI_OVERHEAD + {1'b0, byte_count})
        : 1'b1;
    wire logic accept = frame_ok && addressed && len_ok;
    wire logic reply_on = hdr[0] != modbus_writer_pkg::BROADCAST_ADDR;

    // R16 exception code choice
    wire logic [7:0] next_exc_code =
        (!is_single && !is_multi) ? modbus_writer_pkg::EXC_BAD_FUNC
        : is_single ? (single_ok ? modbus_writer_pkg::EXC_NONE : modbus_writer_pkg::EXC_BAD_ADDR)
        : !count_ok ? modbus_writer_pkg::EXC_BAD_VALUE
        : !multi_ok ? modbus_writer_pkg::EXC_BAD_ADDR
        : modbus_writer_pkg::EXC_NONE;

    // Map write port
    wire logic [6:0] write_count = is_single ? 7'h01 : reg_val[6:0];
    wire logic write_last = wr_i == (write_count - 7'h01);
    wire logic map_we = state == ST_WRITE;
    wire logic [AW-1:0] map_wr_index = off[AW-1:0] + AW'(wr_i);
    wire logic [15:0] map_wr_word = is_single ? reg_val : stage[wr_i];

    // Reply byte selection
    wire logic tx_fire = (state == ST_SEND) && tx_valid && tx_ready;
    wire logic [2:0] tx_last = resp_len + 3'h1;
    wire logic tx_crc_en = tx_fire && (tx_idx < resp_len);
    wire logic [15:0] tx_crc_final = tx_crc_en ? tx_crc_next : tx_crc;
    wire logic [2:0] next_tx_idx = (state == ST_SEND) ? tx_idx + 3'h1 : 3'h0;
    // R14 CRC low byte first
    wire logic [7:0] sel_byte =
        (next_tx_idx == resp_len) ? tx_crc_final[7:0]
        : (next_tx_idx == tx_last) ? tx_crc_final[15:8]
        // R5 R9 function code with high bit set
        : (exc && next_tx_idx == 3'h1) ? (hdr[1] | modbus_writer_pkg::EXC_FLAG)
        : (exc && next_tx_idx == 3'h2) ? exc_code
        // R3 R8 header bytes echoed
        : hdr[next_tx_idx];

    // Register map storage
    for (genvar i = 0; i < DEPTH; i++) begin : g_map
        assign writable[i] = modbus_writer_pkg::map_writable(i);
        assign header_hit[i] = !writable[i] && (17'(i) >= {1'b0, off}) && (17'(i) < span_end);
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                // R10 R11 R12 model ids in place
                map[i] <= modbus_writer_pkg::map_init(i);
            end else if (map_we && map_wr_index == AW'(i) && writable[i]) begin
                // R1 R6 holding register update
                map[i] <= map_wr_word;
            end
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_RX: begin
                if (frame_done) begin
                    next_state = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (!accept) begin
                    next_state = ST_RX;
                end else if (next_exc_code != modbus_writer_pkg::EXC_NONE) begin
                    next_state = reply_on ? ST_SEND : ST_RX;
                end else begin
                    next_state = ST_WRITE;
                end
            end
            ST_WRITE: begin
                // R3 reply only after the write
                if (write_last) begin
                    next_state = reply_on ? ST_SEND : ST_RX;
                end
            end
            ST_SEND: begin
                if (tx_fire && tx_idx == tx_last) begin
                    next_state = ST_RX;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_RX;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            busy <= next_state != ST_RX;
        end
    end

    // Frame capture
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rx_cnt <= 9'h000;
            rx_bad <= 1'b0;
            stage_hi <= 8'h00;
            for (int h = 0; h < modbus_writer_pkg::HDR_BYTES; h++) begin
                hdr[h] <= 8'h00;
            end
        end else if (state != ST_RX) begin
            rx_cnt <= 9'h000;
            rx_bad <= 1'b0;
        end else begin
            if (rx_error) begin
                rx_bad <= 1'b1;
            end
            if (rx_valid) begin
                if (rx_cnt != modbus_writer_pkg::RX_CNT_MAX) begin
                    rx_cnt <= rx_cnt + 9'h001;
                end
                if (rx_cnt < modbus_writer_pkg::DATA_START) begin
                    hdr[rx_cnt[2:0]] <= rx_byte;
                end else if (is_multi && !data_idx[0]) begin
                    stage_hi <= rx_byte;
                end
            end
        end
    end

    // R13 data words high byte first
    always_ff @(posedge ref_clk) begin
        if (rx_take && is_multi && rx_cnt >= modbus_writer_pkg::DATA_START && data_idx[0]
            && data_idx[8:1] < 8'(MAX_WRITE)) begin
            stage[data_idx[7:1]] <= {stage_hi, rx_byte};
        end
    end

    // Decision and write sequencing
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            exc <= 1'b0;
            exc_code <= modbus_writer_pkg::EXC_NONE;
            resp_len <= modbus_writer_pkg::RESP_LEN_OK;
            wr_i <= 7'h00;
            wr_strobe <= 1'b0;
            wr_addr <= 16'h0000;
            wr_data <= 16'h0000;
            map_rd_data <= 16'h0000;
        end else begin
            if (state == ST_CHECK) begin
                exc <= next_exc_code != modbus_writer_pkg::EXC_NONE;
                exc_code <= next_exc_code;
                resp_len <= (next_exc_code != modbus_writer_pkg::EXC_NONE)
                    ? modbus_writer_pkg::RESP_LEN_EXC : modbus_writer_pkg::RESP_LEN_OK;
                wr_i <= 7'h00;
            end else if (map_we) begin
                // R18 ascending address order
                wr_i <= wr_i + 7'h01;
            end
            wr_strobe <= map_we;
            if (map_we) begin
                wr_addr <= reg_addr + {9'h000, wr_i};
                wr_data <= map_wr_word;
            end
            map_rd_data <= (map_rd_index < AW'(DEPTH)) ? map[map_rd_index] : 16'h0000;
        end
    end

    // Reply transmitter
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tx_valid <= 1'b0;
            tx_byte <= 8'h00;
            tx_idx <= 3'h0;
        end else if (state != ST_SEND && next_state == ST_SEND) begin
            tx_valid <= 1'b1;
            tx_idx <= 3'h0;
            tx_byte <= sel_byte;
        end else if (tx_fire) begin
            if (tx_idx == tx_last) begin
                tx_valid <= 1'b0;
            end else begin
                tx_idx <= next_tx_idx;
                tx_byte <= sel_byte;
            end
        end
    end

    // R15 receive check
    modbus_crc16 u_rx_crc (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clear(state != ST_RX),
        .en(rx_take),
        .data(rx_byte),
        .crc(rx_crc),
        .crc_next()
    );

    // R14 reply check value
    modbus_crc16 u_tx_crc (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clear(state != ST_SEND),
        .en(tx_crc_en),
        .data(tx_byte),
        .crc(tx_crc),
        .crc_next(tx_crc_next)
    );

endmodule

// ---- sim/modbus_writer_assertions.sv ----
`timescale 1ns/10ps
module modbus_writer_assertions (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Link
    input wire logic [7:0] slave_addr,
    input wire logic rx_error,
    input wire logic rx_frame_end,
    input wire logic [7:0] tx_byte,
    input wire logic tx_valid,
    input wire logic tx_ready,
    // Writes and map
    input wire logic wr_strobe,
    input wire logic busy,
    input wire logic [modbus_writer_pkg::MAP_AW-1:0] map_rd_index,
    input wire logic [15:0] map_rd_data
);
    logic [3:0] idx;
    logic exc;
    logic bad;
    logic [1:0] up;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // Reply byte position
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) idx <= 4'h0;
        else if (!tx_valid) idx <= 4'h0;
        else if (tx_ready) idx <= idx + 4'h1;
    end
    // Exception flag of the reply function byte
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) exc <= 1'b0;
        else if (tx_valid && tx_ready && idx == 4'h1) exc <= tx_byte[7];
    end
    // Character error seen in the current frame
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) bad <= 1'b0;
        else if (rx_frame_end) bad <= 1'b0;
        else if (rx_error) bad <= 1'b1;
    end
    // Cycles since reset release
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) up <= 2'h0;
        else if (up != 2'h3) up <= up + 2'h1;
    end
    sequence s_take;
        tx_valid && tx_ready;
    endsequence
    sequence s_quiet;
        (!tx_valid && !wr_strobe) [*8];
    endsequence
    property p_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte);
    endproperty
    a_hold: assert property (p_hold) else $error("reply byte dropped");
    property p_first;
        $rose(tx_valid) |-> tx_byte == slave_addr;
    endproperty
    a_first: assert property (p_first) else $error("reply address wrong");
    property p_code;
        tx_valid && idx == 4'h2 && exc |-> tx_byte inside {8'h01, 8'h02, 8'h03};
    endproperty
    a_code: assert property (p_code) else $error("bad exception code");
    property p_exc_len;
        s_take ##0 (idx == 4'h4 && exc) |=> !tx_valid;
    endproperty
    a_exc_len: assert property (p_exc_len) else $error("exception length");
    property p_ok_len;
        s_take ##0 (idx == 4'h7 && !exc) |=> !tx_valid;
    endproperty
    a_ok_len: assert property (p_ok_len) else $error("reply length");
    property p_late_write;
        tx_valid |=> !wr_strobe;
    endproperty
    a_late_write: assert property (p_late_write) else $error("write after reply");
    property p_strobe_busy;
        wr_strobe |-> $past(busy);
    endproperty
    a_strobe_busy: assert property (p_strobe_busy) else $error("write while idle");
    property p_drop;
        rx_frame_end && (bad || rx_error) |=> s_quiet;
    endproperty
    a_drop: assert property (p_drop) else $error("errored frame answered");
    property p_map_first;
        up == 2'h3 && map_rd_index == '0 |=> map_rd_data == 16'h0001;
    endproperty
    a_map_first: assert property (p_map_first) else $error("first model");
    property p_map_last;
        up == 2'h3 && map_rd_index == 8'hAE |=> map_rd_data == 16'hFFFF;
    endproperty
    a_map_last: assert property (p_map_last) else $error("end model");
endmodule

bind modbus_rtu_register_writer modbus_writer_assertions chk (
    .ref_clk, .rstn, .slave_addr, .rx_error, .rx_frame_end, .tx_byte, .tx_valid,
    .tx_ready, .wr_strobe, .busy, .map_rd_index, .map_rd_data);

// ---- sim/modbus_master_model.sv ----
`timescale 1ns/10ps
module modbus_master_model (
    // Clock
    input wire logic ref_clk,
    // Request characters
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic rx_error,
    output logic rx_frame_end,
    // Reply pacing
    output logic tx_ready
);
    logic slow = 1'b0;
    initial begin
        rx_byte = 8'h00;
        rx_valid = 1'b0;
        rx_error = 1'b0;
        rx_frame_end = 1'b0;
        tx_ready = 1'b1;
    end
    // Prompt or randomly stalling reader
    always @(negedge ref_clk) begin
        tx_ready <= slow ? 1'($urandom) : 1'b1;
    end
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = modbus_writer_pkg::CRC_SEED;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ modbus_writer_pkg::CRC_POLY : c >> 1;
        end
        return c;
    endfunction
    // Send a frame; optional bad check or character error
    task automatic send(input logic [7:0] f[$], input bit bad, input bit perr);
        logic [15:0] c;
        c = crc16(f) ^ {15'h0, bad};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        foreach (f[i]) begin
            @(negedge ref_clk);
            rx_byte <= f[i];
            rx_valid <= 1'b1;
            rx_error <= perr && i == 2;
        end
        @(negedge ref_clk);
        rx_byte <= ~f[f.size() - 1];
        rx_valid <= 1'b0;
        rx_error <= 1'b0;
        rx_frame_end <= 1'b1;
        @(negedge ref_clk);
        rx_frame_end <= 1'b0;
    endtask
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
    localparam int AW = modbus_writer_pkg::MAP_AW;
    localparam logic [15:0] B = modbus_writer_pkg::MAP_BASE;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] slave_addr = 8'h0A;
    logic [AW-1:0] map_rd_index = '0;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic rx_error;
    logic rx_frame_end;
    logic tx_ready;
    logic [7:0] tx_byte;
    logic tx_valid;
    logic wr_strobe;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;
    logic [15:0] map_rd_data;
    logic busy;
    int mismatches = 0;
    int n_checks = 0;
    logic [7:0] exp_tx[$];
    logic [31:0] exp_wr[$];

    always #12.5 ref_clk = ~ref_clk;

    modbus_master_model host (.ref_clk, .rx_byte, .rx_valid, .rx_error, .rx_frame_end,
        .tx_ready);
    modbus_rtu_register_writer uut (.ref_clk, .rstn, .slave_addr, .rx_byte, .rx_valid,
        .rx_error, .rx_frame_end, .tx_byte, .tx_valid, .tx_ready, .wr_strobe, .wr_addr,
        .wr_data, .map_rd_index, .map_rd_data, .busy);

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        if (mismatches == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Outputs against the oldest notes
    always @(posedge ref_clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            check(tx_byte, exp_tx.size() ? exp_tx.pop_front() : 'x);
        end
        if (wr_strobe === 1'b1) begin
            check({wr_addr, wr_data}, exp_wr.size() ? exp_wr.pop_front() : 'x);
        end
    end

    function automatic void reply(input logic [7:0] r[$]);
        logic [15:0] c;
        c = host.crc16(r);
        r.push_back(c[7:0]);
        r.push_back(c[15:8]);
        exp_tx = {exp_tx, r};
    endfunction

    task automatic run(input logic [7:0] f[$], input bit bad = 0, input bit perr = 0);
        int i;
        host.send(f, bad, perr);
        repeat (3) @(negedge ref_clk);
        i = 0;
        while (busy !== 1'b0 && i < 400) begin
            @(negedge ref_clk);
            i++;
        end
        check(i < 400, 1);
        check(exp_tx.size() + exp_wr.size(), 0);
    endtask

    // Code 0 accepted, FF silently dropped, else exception
    task automatic w06(input logic [7:0] sa, input logic [15:0] a, input logic [15:0] d,
        input logic [7:0] code, input bit bad = 0, input bit perr = 0);
        logic [7:0] f[$];
        f = '{sa, 8'h06, a[15:8], a[7:0], d[15:8], d[7:0]};
        if (sa == slave_addr && code == 8'h00) reply(f);
        else if (sa == slave_addr && code != 8'hFF) reply('{sa, 8'h86, code});
        if (code == 8'h00) exp_wr.push_back({a, d});
        run(f, bad, perr);
    endtask

    task automatic w16(input logic [15:0] a, input int n, input int bc, input logic [7:0] code);
        logic [7:0] f[$];
        logic [15:0] d;
        f = '{slave_addr, 8'h10, a[15:8], a[7:0], 8'(n >> 8), 8'(n), 8'(bc)};
        for (int k = 0; k < bc / 2; k++) begin
            d = 16'($urandom);
            f.push_back(d[15:8]);
            f.push_back(d[7:0]);
            if (code == 8'h00) exp_wr.push_back({a + 16'(k), d});
        end
        if (code == 8'h00) reply('{slave_addr, 8'h10, a[15:8], a[7:0], 8'(n >> 8), 8'(n)});
        else reply('{slave_addr, 8'h90, code});
        run(f);
    endtask

    initial begin
        logic [15:0] a;
        logic [15:0] d;
        void'($urandom(3));
        repeat (6) @(negedge ref_clk);
        rstn = 1'b1;
        for (int m = 0; m < 30; m++) begin
            map_rd_index <= AW'(m * 6);
            @(negedge ref_clk);
            check(map_rd_data, m == 0 ? 16'h0001 : m == 29 ? 16'hFFFF :
                modbus_writer_pkg::MODEL_IDS[m]);
        end
        w06(slave_addr, B + 16'h2, 16'($urandom), 8'h00);
        host.slow = 1'b1;
        w06(slave_addr, B + 16'h3, 16'($urandom), 8'h00);
        w16(B + 16'h8, 2, 4, 8'h00);
        w16(B + 16'h2, 4, 8, 8'h00);
        w16(B + 16'h4, 3, 6, 8'h02);
        w16(B + 16'h2, 2, 6, 8'h03);
        w16(B + 16'h2, 0, 0, 8'h03);
        w16(B + 16'h2, 124, 248, 8'h03);
        w16(B + 16'h2, 123, 246, 8'h02);
        w06(slave_addr, B, 16'h1234, 8'h02);
        w06(slave_addr, B + 16'd176, 16'h1234, 8'h02);
        w06(slave_addr, 16'h0000, 16'h1234, 8'h02);
        w06(slave_addr, B + 16'h2, 16'h5555, 8'hFF, 1, 0);
        w06(slave_addr, B + 16'h2, 16'h5555, 8'hFF, 0, 1);
        w06(8'h0B, B + 16'h2, 16'h5555, 8'hFF);
        w06(8'h00, B + 16'h4, 16'($urandom), 8'h00);
        reply('{slave_addr, 8'h83, 8'h01});
        run('{slave_addr, 8'h03, 8'h9C, 8'h40, 8'h00, 8'h01});
        host.slow = 1'b0;
        for (int j = 0; j < 8; j++) begin
            a = B + 16'(($urandom % 29) * 6 + 2 + $urandom % 4);
            d = 16'($urandom);
            w06(slave_addr, a, d, 8'h00);
            map_rd_index <= AW'(a - B);
            @(negedge ref_clk);
            check(map_rd_data, d);
        end
        wrap_up();
    end

    initial begin
        #400us;
        mismatches++;
        wrap_up();
    end
endmodule
